// ===== include/cantxs_pkg.sv
/*
 Package for the transmit buffer status and abort block: register offsets,
 field widths and reset values. Assumes a 32-bit APB register bus.
*/
package cantxs_pkg;
   localparam int unsigned cantxs_num_buffers = 3;
   localparam int unsigned cantxs_addr_width = 4;
   localparam logic [3:0] cantxs_off_flags = 4'h0;
   localparam logic [3:0] cantxs_off_irq_en = 4'h4;
   localparam logic [3:0] cantxs_off_abort_rq = 4'h8;
   localparam logic [3:0] cantxs_off_abort_ak = 4'hc;
   localparam logic [3:0] cantxs_off_control = 4'h0;
   localparam logic [2:0] cantxs_flags_reset = 3'h7;
   localparam logic [2:0] cantxs_zero_reset = 3'h0;
   localparam int unsigned cantxs_bit_init_rq = 0;
   localparam int unsigned cantxs_bit_listen = 1;
   localparam int unsigned cantxs_ctrl_width = 2;
endpackage

// ===== verilog/cantxs_status.sv
/*
 Transmit buffer empty flags, interrupt enables, abort requests and abort
 acknowledges of a CAN controller with three transmit buffers, APB slave.
 Assumes a protocol engine that reports per-buffer transmit success, abort
 grant and buffer start, and an init handshake partner for init_ack.
*/
// Chosen here: the register offsets and the APB interface to the registers.
// Summary of operation
// - Empty flags clear on write 1, ignore 0; writes only outside init mode.
// - Init mode (request and acknowledge high) holds empty flags at reset value; control stays at reset here, so init mode is never entered.
// - One empty flag per buffer; 1 empty, 0 loaded and scheduled.
// - Successful transmission of a buffer sets its empty flag.
// - Granted abort sets the buffer's empty flag.
// - Interrupt pending while any enabled buffer's empty flag is set.
// - Clearing an empty flag clears that buffer's abort acknowledge.
// - Setting an empty flag for any cause clears its abort request.
// - Listen-only mode refuses flag clears and starts no transmission; control stays at reset here, so listen_only stays 0.
// - Buffer access blocked while its empty flag is 0 and scheduled.
// - One interrupt enable per buffer; 1 lets its empty event interrupt.
// - Interrupt enables reset in init mode; writable only outside it.
// - Abort requests reset in init mode; writable only outside it.
// - Abort granted only before start, or after lost arbitration or error.
// - Granted abort sets empty flag and acknowledge; interrupt if enabled.
// - Writes of 0 to abort requests are ignored.
// - Abort acknowledge shows a queued message was really cancelled.
// - Abort acknowledges read-only, one per buffer, reset in init mode.
`timescale 1ns/10ps
`default_nettype none
module cantxs_status
#(
   parameter int unsigned num_buffers = cantxs_pkg::cantxs_num_buffers
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cantxs_pkg::cantxs_addr_width-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic init_mode_acknowledge,
   input wire logic [num_buffers-1:0] tx_success,
   input wire logic [num_buffers-1:0] tx_abort_grantable,
   input wire logic [num_buffers-1:0] buffer_access_req,
   output logic init_mode_request,
   output logic listen_only,
   output logic [num_buffers-1:0] tx_request,
   output logic [num_buffers-1:0] buffer_access_blocked,
   output logic tx_irq
);
   import cantxs_pkg::*;

   // Register fields and reset constants are three bits wide
   if (num_buffers != cantxs_num_buffers)
   begin : g_width_check
      $error("num_buffers must equal the register field width");
   end

   logic [num_buffers-1:0] tx_buffer_empty_flags;
   logic [num_buffers-1:0] tx_empty_irq_enables;
   logic [num_buffers-1:0] tx_abort_requests;
   logic [num_buffers-1:0] tx_abort_acknowledges;
   logic [cantxs_ctrl_width-1:0] control;
   logic init_mode;
   logic wr_access;
   logic rd_access;
   logic wr_flags;
   logic wr_irq_en;
   logic wr_abort;
   logic wr_control;
   logic [num_buffers-1:0] abort_grant;
   logic [num_buffers-1:0] next_flags;
   logic [num_buffers-1:0] flag_set;
   logic [num_buffers-1:0] flag_clr;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic [3:0] reg_index;
   logic map_hit;

   // No address above the four registers exists, so control stays at reset
   logic paddr_hi;
   assign paddr_hi = 1'b0;
   assign init_mode = control[cantxs_bit_init_rq] & init_mode_acknowledge;
   assign wr_access = psel & penable & pwrite & ~pready;
   assign rd_access = psel & penable & ~pwrite & ~pready;
   assign reg_index = paddr;
   assign wr_control = wr_access & pstrb[0] & (reg_index == cantxs_off_control) & paddr_hi;
   assign wr_flags = wr_access & pstrb[0] & (reg_index == cantxs_off_flags) & ~init_mode;
   assign wr_irq_en = wr_access & pstrb[0] & (reg_index == cantxs_off_irq_en) & ~init_mode;
   assign wr_abort = wr_access & pstrb[0] & (reg_index == cantxs_off_abort_rq) & ~init_mode;

   // Grant only while the engine reports the buffer as abortable
   assign abort_grant = tx_abort_requests & ~tx_buffer_empty_flags & tx_abort_grantable;
   assign flag_set = tx_success | abort_grant;
   // Listen-only refuses clears; a set in the same cycle wins
   assign flag_clr = (wr_flags & ~control[cantxs_bit_listen]) ?
                     pwdata[num_buffers-1:0] : '0;
   assign next_flags = (tx_buffer_empty_flags & ~flag_clr) | flag_set;

   // Per-buffer state: empty flag, enable, abort request and acknowledge
   generate
      for (genvar b = 0; b < num_buffers; b++)
      begin : g_buffer
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               tx_buffer_empty_flags[b] <= cantxs_flags_reset[b];
            end
            else if (init_mode)
            begin
               tx_buffer_empty_flags[b] <= cantxs_flags_reset[b];
            end
            else
            begin
               tx_buffer_empty_flags[b] <= next_flags[b];
            end
         end

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               tx_empty_irq_enables[b] <= cantxs_zero_reset[b];
            end
            else if (init_mode)
            begin
               tx_empty_irq_enables[b] <= cantxs_zero_reset[b];
            end
            else if (wr_irq_en)
            begin
               tx_empty_irq_enables[b] <= pwdata[b];
            end
         end

         // A flag that becomes set in the same cycle as a request write wins
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               tx_abort_requests[b] <= cantxs_zero_reset[b];
            end
            else if (init_mode)
            begin
               tx_abort_requests[b] <= cantxs_zero_reset[b];
            end
            else if (flag_set[b] | (next_flags[b] & ~tx_buffer_empty_flags[b]))
            begin
               tx_abort_requests[b] <= 1'b0;
            end
            else if (wr_abort & pwdata[b])
            begin
               tx_abort_requests[b] <= 1'b1;
            end
         end

         // A grant in the same cycle as a software clear keeps the acknowledge
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               tx_abort_acknowledges[b] <= cantxs_zero_reset[b];
            end
            else if (init_mode)
            begin
               tx_abort_acknowledges[b] <= cantxs_zero_reset[b];
            end
            else if (abort_grant[b])
            begin
               tx_abort_acknowledges[b] <= 1'b1;
            end
            else if (flag_clr[b])
            begin
               tx_abort_acknowledges[b] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         control <= '0;
      end
      else if (wr_control)
      begin
         control <= pwdata[cantxs_ctrl_width-1:0];
      end
   end

   always_comb
   begin
      map_hit = 1'b1;
      next_prdata = '0;
      case (reg_index)
         cantxs_off_flags: next_prdata[num_buffers-1:0] = tx_buffer_empty_flags;
         cantxs_off_irq_en: next_prdata[num_buffers-1:0] = tx_empty_irq_enables;
         cantxs_off_abort_rq: next_prdata[num_buffers-1:0] = tx_abort_requests;
         cantxs_off_abort_ak: next_prdata[num_buffers-1:0] = tx_abort_acknowledges;
         default: map_hit = 1'b0;
      endcase
      next_pslverr = ~map_hit;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & next_pslverr;
         prdata <= rd_access ? next_prdata : '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_irq <= 1'b0;
         tx_request <= '0;
         buffer_access_blocked <= '0;
         init_mode_request <= 1'b0;
         listen_only <= 1'b0;
      end
      else
      begin
         tx_irq <= |(next_flags & tx_empty_irq_enables & {num_buffers{~init_mode}});
         tx_request <= control[cantxs_bit_listen] ? '0 : ~next_flags;
         buffer_access_blocked <= ~next_flags & buffer_access_req;
         init_mode_request <= control[cantxs_bit_init_rq];
         listen_only <= control[cantxs_bit_listen];
      end
   end
endmodule
`default_nettype wire

// ===== bench/cantxs_assertions.sv
/* Port checks for cantxs_status.
   Bound to the design from the bench top file. */
`timescale 1ns/10ps
`default_nettype none
module cantxs_assertions
#(
   parameter int unsigned num_buffers = 3
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic init_mode_request,
   input wire logic listen_only,
   input wire logic [num_buffers-1:0] tx_success,
   input wire logic [num_buffers-1:0] tx_request,
   input wire logic tx_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   ans_time_a: assert property (s_wait |=> pready) else $error("pready late");
   pulse_a: assert property (pready |=> !pready) else $error("pready held");
   ready_src_a: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
   err_ok_a: assert property (pslverr |-> pready) else $error("pslverr alone");
   mode_off_a: assert property (!init_mode_request && !listen_only) else $error("mode on");
   irq_src_a: assert property (tx_irq |-> tx_request != '1) else $error("irq, none empty");
   done_a: assert property (tx_success[0] && tx_request[0] |-> ##[1:2] !tx_request[0])
      else $error("success kept request");
   req_src_a: assert property ($rose(tx_request[0]) |-> $past(psel && pwrite, 2)
      || $past(psel && pwrite, 3)) else $error("request without write");
endmodule
`default_nettype wire

// ===== bench/cantxs_engine.sv
/* Protocol engine model: success after a delay, abort grant on command.
   Assumes tx_request from cantxs_status. */
`timescale 1ns/10ps
`default_nettype none
module cantxs_engine (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hold,
   input wire logic grant,
   input wire logic [2:0] tx_request,
   output logic [2:0] tx_success,
   output logic [2:0] tx_abort_grantable
);
   logic [3:0] cnt;
   assign tx_abort_grantable = grant ? tx_request : 3'h0;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cnt <= 4'h0;
         tx_success <= 3'h0;
      end
      else
      begin
         tx_success <= (cnt == 4'h8) ? tx_request : 3'h0;
         cnt <= (cnt == 4'h8 || hold || tx_request == 3'h0) ? 4'h0 : cnt + 4'h1;
      end
endmodule
`default_nettype wire

// ===== bench/cantxs_status_test.sv
/* Self-checking bench for cantxs_status.
   Assumes cantxs_engine and cantxs_assertions. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t got %h", $time, a); end end
module cantxs_status_test;
   import cantxs_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hold = 1, grant = 0;
   logic [3:0] paddr = 4'h0;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [2:0] req = 3'h0, en, pat, tx_success, tx_abort_grantable, tx_request, blocked;
   logic pready, pslverr, e, tx_irq;
   int error_cnt = 0, n_tests = 0, seed = 15;
   initial forever #2.5 pclk = ~pclk;
   cantxs_status u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
      .prdata, .pready, .pslverr, .init_mode_acknowledge(1'b0), .tx_success, .tx_abort_grantable,
      .buffer_access_req(req), .init_mode_request(), .listen_only(), .tx_request,
      .buffer_access_blocked(blocked), .tx_irq);
   cantxs_engine u_eng (.pclk, .presetn, .hold, .grant, .tx_request, .tx_success,
      .tx_abort_grantable);
   task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
      if (k >= 20)
      begin
         error_cnt++;
         $display("[FAIL] %0t no pready", $time);
         report_and_stop;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [2:0] x);
      apb(1'b0, a, 32'h0);
      `CHK(r, {29'h0, x})
   endtask
   task automatic wr(input logic [3:0] a, input logic [2:0] x);
      apb(1'b1, a, {29'h0, x});
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      #100000;
      error_cnt++;
      report_and_stop;
   end
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(4'h0, 3'h7);
      rd(4'h4, 3'h0);
      rd(4'h8, 3'h0);
      rd(4'hc, 3'h0);
      apb(1'b0, 4'h2, 32'h0);
      `CHK(e, 1'b1)
      $display("reset values done");
      repeat (6)
      begin
         en = 3'($random(seed));
         pat = 3'($random(seed));
         req <= 3'($random(seed));
         wr(4'h4, en);
         rd(4'h4, en);
         `CHK(tx_irq, |en)
         wr(4'h0, pat);
         wr(4'h0, 3'h0);
         rd(4'h0, ~pat);
         `CHK(tx_request, pat)
         `CHK(blocked, req & pat)
         `CHK(tx_irq, |(en & ~pat))
         hold <= 1'b0;
         repeat (12) @(posedge pclk);
         rd(4'h0, 3'h7);
         hold <= 1'b1;
         $display("random round done");
      end
      wr(4'h0, 3'h2);
      wr(4'h8, 3'h2);
      wr(4'h8, 3'h0);
      rd(4'h8, 3'h2);
      rd(4'h0, 3'h5);
      grant <= 1'b1;
      rd(4'h0, 3'h7);
      rd(4'hc, 3'h2);
      rd(4'h8, 3'h0);
      grant <= 1'b0;
      wr(4'h0, 3'h2);
      rd(4'hc, 3'h0);
      $display("abort done");
      report_and_stop;
   end
endmodule
bind cantxs_status cantxs_assertions #(.num_buffers(num_buffers)) u_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .pready, .pslverr, .init_mode_request, .listen_only, .tx_success,
   .tx_request, .tx_irq);
`default_nettype wire
